// ---- ldr_pkg.sv ----
// package: constants, modes and carriers of the large dual-port ram block
package ldr_pkg;
  localparam int MEM_BITS = 589824;
  localparam int ROW_W    = 144;
  localparam int ROWS     = MEM_BITS / ROW_W;
  localparam int ROW_AW   = 12;
  localparam int LANE_W   = 9;
  localparam int BYTE_W   = 8;
  localparam int LANES    = 16;
  localparam int ADDR_W   = 16;
  localparam int PORT_W   = 72;
  localparam int BE_W     = 8;
  localparam int PTR_W    = 17;

  // register byte offsets
  localparam logic [7:0] CFG_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;

  // config field positions
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_WIDA_LSB = 2;
  localparam int CFG_WIDB_LSB = 5;
  localparam int CFG_NOPAR    = 8;
  localparam int CFG_OREGA    = 9;
  localparam int CFG_OREGB    = 10;
  localparam int CFG_CKM_LSB  = 11;

  // status field positions
  localparam int STAT_REJ   = 0;
  localparam int STAT_EMPTY = 1;
  localparam int STAT_FULL  = 2;
  localparam int STAT_LVL   = 8;

  // width codes: lane count is 1 << code
  localparam logic [2:0] WID_9   = 3'h0;
  localparam logic [2:0] WID_18  = 3'h1;
  localparam logic [2:0] WID_36  = 3'h2;
  localparam logic [2:0] WID_72  = 3'h3;
  localparam logic [2:0] WID_144 = 3'h4;

  typedef enum logic [1:0] {MODE_TDP, MODE_SDP, MODE_SP, MODE_FIFO} ldr_mode_t;
  typedef enum logic [1:0] {CK_INDEP, CK_INOUT, CK_RDWR} ldr_ckm_t;

  typedef struct packed {
    ldr_mode_t  mode;
    logic [2:0] wid_a;
    logic [2:0] wid_b;
    logic       no_par;
    logic       oreg_a;
    logic       oreg_b;
    ldr_ckm_t   ckm;
  } ldr_cfg_t;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0]   be;
    logic [PORT_W-1:0] din;
  } ldr_req_t;

  localparam ldr_cfg_t CFG_RST = '{mode: MODE_TDP, wid_a: WID_9, wid_b: WID_9, no_par: 1'h0,
                                   oreg_a: 1'h0, oreg_b: 1'h0, ckm: CK_INDEP};
endpackage

// ---- ldr_ram.sv ----
// large dual-port ram block: array, port registers, config and status over wishbone
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - array holds 589,824 bits, parity bits included
// - modes: true dual-port, simple dual-port, single-port, fifo
// - no preload; contents undefined after power-up
// - every port input is registered before use
// - data output register per port is optional
// - shapes 64Kx9/8 up to 4Kx144/128
// - 144-bit shape refused in true dual-port mode
// - mixed widths allowed except in fifo; 144 pairs only with 144, except port b in single-port
// - registered write select alone picks read or write
// - write needs write select and, above 9 bits, the lane mask bit
// - lane masking only on 18, 36, 72, 144 bit writes
// - wide write uses port b mask above port a mask
// - mask bit i gates data bits 9i+8 to 9i
// - any mix of mask bits is accepted
// - parity-less shapes mask 8-bit lanes in same order
// - input registers share one clock, outputs may use other
// - 72-bit write and read data per port
// - independent mode: each port on its own enable
// - input/output mode: inputs on one, outputs on other
// - read/write mode: write side and read side separate
// - unmasked lanes keep old contents
module ldr_ram (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ce_a_i,
  input  wire logic        clr_a_i,
  input  wire logic        we_a_i,
  input  wire logic [15:0] addr_a_i,
  input  wire logic [7:0]  be_a_i,
  input  wire logic [71:0] din_a_i,
  output logic      [71:0] dout_a_o,
  input  wire logic        ce_b_i,
  input  wire logic        clr_b_i,
  input  wire logic        we_b_i,
  input  wire logic [15:0] addr_b_i,
  input  wire logic [7:0]  be_b_i,
  input  wire logic [71:0] din_b_i,
  output logic      [71:0] dout_b_o
);
  localparam int P = 2;

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [3:0] lane_off(input logic [2:0] k, input logic [15:0] a);
    lane_off = 4'(a[3:0] << k);
  endfunction

  function automatic logic [11:0] row_of(input logic [2:0] k, input logic [15:0] a);
    row_of = 12'(a >> (3'h4 - k));
  endfunction

  function automatic logic [15:0] lane_span(input logic [2:0] k);
    unique case (k)
      ldr_pkg::WID_9:  lane_span = 16'h0001;
      ldr_pkg::WID_18: lane_span = 16'h0003;
      ldr_pkg::WID_36: lane_span = 16'h000f;
      ldr_pkg::WID_72: lane_span = 16'h00ff;
      default:         lane_span = 16'hffff;
    endcase
  endfunction

  function automatic logic [143:0] bits_of(input logic [15:0] l);
    for (int i = 0; i < ldr_pkg::LANES; i++) begin
      bits_of[i*ldr_pkg::LANE_W +: ldr_pkg::LANE_W] = {ldr_pkg::LANE_W{l[i]}};
    end
  endfunction

  function automatic logic [143:0] expand(input logic [127:0] d);
    for (int i = 0; i < ldr_pkg::LANES; i++) begin
      expand[i*ldr_pkg::LANE_W +: ldr_pkg::LANE_W] = {1'h0, d[i*ldr_pkg::BYTE_W +: ldr_pkg::BYTE_W]};
    end
  endfunction

  function automatic logic [127:0] compress(input logic [143:0] r);
    for (int i = 0; i < ldr_pkg::LANES; i++) begin
      compress[i*ldr_pkg::BYTE_W +: ldr_pkg::BYTE_W] = r[i*ldr_pkg::LANE_W +: ldr_pkg::BYTE_W];
    end
  endfunction

  function automatic logic [71:0] half(input logic [143:0] s, input logic np, input logic up);
    if (np) begin
      half = up ? {8'h00, s[127:64]} : {8'h00, s[63:0]};
    end else begin
      half = up ? s[143:72] : s[71:0];
    end
  endfunction

  // legal mode, shape and clock pairings
  function automatic logic cfg_ok(input logic [31:0] m);
    logic [2:0] wa;
    logic [2:0] wb;
    logic [1:0] ck;
    wa = m[ldr_pkg::CFG_WIDA_LSB +: 3];
    wb = m[ldr_pkg::CFG_WIDB_LSB +: 3];
    ck = m[ldr_pkg::CFG_CKM_LSB +: 2];
    cfg_ok = (wa <= ldr_pkg::WID_144) && (wb <= ldr_pkg::WID_144) && (ck <= 2'(ldr_pkg::CK_RDWR));
    unique case (ldr_pkg::ldr_mode_t'(m[ldr_pkg::CFG_MODE_LSB +: 2]))
      ldr_pkg::MODE_TDP:  cfg_ok = cfg_ok && wa != ldr_pkg::WID_144 && wb != ldr_pkg::WID_144
                                   && ck != 2'(ldr_pkg::CK_RDWR);
      ldr_pkg::MODE_SDP:  cfg_ok = cfg_ok && ((wa == ldr_pkg::WID_144) == (wb == ldr_pkg::WID_144));
      ldr_pkg::MODE_SP:   cfg_ok = cfg_ok && wa != ldr_pkg::WID_144 && ck == 2'(ldr_pkg::CK_INDEP);
      ldr_pkg::MODE_FIFO: cfg_ok = cfg_ok && wa == wb;
    endcase
  endfunction

  // ****************************************************
  // state and derived signals
  // ****************************************************
  // one row per 144 bits, never initialised
  logic [143:0]      mem [ldr_pkg::ROWS];
  ldr_pkg::ldr_cfg_t cfg, next_cfg;
  logic              rej, next_rej, ack, next_ack, wb_go;
  logic [31:0]       rdat, next_rdat, cur_word, merged;
  logic [16:0]       wptr, next_wptr, rptr, next_rptr, level, depth;
  logic [7:0]        hi_be, next_hi_be;
  logic [71:0]       hi_din, next_hi_din;
  logic              tdp, fifo, wide, full, empty;
  ldr_pkg::ldr_req_t req_in [P];
  ldr_pkg::ldr_req_t req [P];
  ldr_pkg::ldr_req_t next_req [P];
  logic              vld [P], next_vld [P];
  logic [71:0]       rd1 [P], next_rd1 [P], dout [P], next_dout [P], rsel [P];
  logic              ce [P], clr [P], in_en [P], out_en [P], oreg [P];
  logic              wr_go [P], read_strobe [P];
  logic [2:0]        wid [P];
  logic [15:0]       ea [P], be_full [P], lm [P];
  logic [3:0]        off [P];
  logic [11:0]       row_w [P];
  logic [143:0]      bm [P], wd [P], rrow [P], sl [P];

  assign req_in[0] = '{we: we_a_i, addr: addr_a_i, be: be_a_i, din: din_a_i};
  assign req_in[1] = '{we: we_b_i, addr: addr_b_i, be: be_b_i, din: din_b_i};

  always_comb begin
    tdp    = cfg.mode == ldr_pkg::MODE_TDP;
    fifo   = cfg.mode == ldr_pkg::MODE_FIFO;
    wide   = cfg.wid_a == ldr_pkg::WID_144;
    depth  = 17'h1_0000 >> cfg.wid_a;
    level  = wptr - rptr;
    full   = level == depth;
    empty  = level == 17'h0_0000;
    wid[0] = cfg.wid_a;
    wid[1] = cfg.wid_b;
    oreg[0] = cfg.oreg_a;
    oreg[1] = cfg.oreg_b;
    ce[0]  = ce_a_i;
    ce[1]  = ce_b_i;
    clr[0] = clr_a_i;
    clr[1] = clr_b_i;
    for (int p = 0; p < P; p++) begin
      in_en[p]  = (cfg.ckm == ldr_pkg::CK_INOUT) ? ce[0] : ce[p];
      out_en[p] = (cfg.ckm == ldr_pkg::CK_INOUT) ? ce[1] : ce[p];
      ea[p]     = fifo ? 16'(((p == 0) ? wptr : rptr) & (depth - 17'h1)) : req[p].addr;
      off[p]    = lane_off(wid[p], ea[p]);
      row_w[p]  = row_of(wid[p], ea[p]);
      // wide write mask: port b lanes on top
      be_full[p] = wide ? {hi_be, req[p].be} : {8'h00, req[p].be};
      // narrowest shape always writes its lane
      lm[p] = 16'(((wid[p] == ldr_pkg::WID_9) ? 16'h0001 : (be_full[p] & lane_span(wid[p]))) << off[p]);
      bm[p] = bits_of(lm[p]);
      // byte lanes sit in the low eight bits of each slot
      wd[p] = cfg.no_par ? expand({wide ? hi_din[63:0] : 64'h0, req[p].din[63:0]})
                         : {wide ? hi_din : 72'h0, req[p].din};
      wd[p] = wd[p] << (off[p] * ldr_pkg::LANE_W);
      rrow[p] = mem[row_w[p]];
      sl[p] = (rrow[p] >> (off[p] * ldr_pkg::LANE_W)) & bits_of(lane_span(wid[p]));
      if (cfg.no_par) begin
        sl[p] = {16'h0000, compress(sl[p])};
      end
      // registered select decides; port b writes only in true dual-port
      wr_go[p] = vld[p] & req[p].we & ((p == 0) | tdp) & ~(fifo & full);
      read_strobe[p] = vld[p] & ~req[p].we & ~(fifo & empty)
                       & ((p == 0) ? (tdp | (cfg.mode == ldr_pkg::MODE_SP)) : (cfg.mode != ldr_pkg::MODE_SP));
    end
    // wide read is split over both 72-bit outputs
    rsel[0] = wide ? half(sl[1], cfg.no_par, 1'h0) : half(sl[0], cfg.no_par, 1'h0);
    rsel[1] = wide ? half(sl[1], cfg.no_par, 1'h1) : half(sl[1], cfg.no_par, 1'h0);
  end

  // ****************************************************
  // array write
  // ****************************************************
  // read-modify-write keeps unmasked lanes
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < P; p++) begin
      if (wr_go[p]) begin
        mem[row_w[p]] <= (rrow[p] & ~bm[p]) | (wd[p] & bm[p]);
      end
    end
  end

  // ****************************************************
  // port registers
  // ****************************************************
  always_comb begin
    next_hi_be  = hi_be;
    next_hi_din = hi_din;
    if (in_en[0] && wide) begin
      next_hi_be  = be_b_i;
      next_hi_din = din_b_i;
    end
    if (clr[0]) begin
      next_hi_be  = 8'h00;
      next_hi_din = 72'h0;
    end
    for (int p = 0; p < P; p++) begin
      // capture only on the port's input enable
      next_req[p]  = in_en[p] ? req_in[p] : req[p];
      next_vld[p]  = in_en[p];
      next_rd1[p]  = rd1[p];
      next_dout[p] = dout[p];
      // bypass loads output at once, else via second stage
      if (wide ? read_strobe[1] : read_strobe[p]) begin
        next_rd1[p] = rsel[p];
        if (!oreg[p]) begin
          next_dout[p] = rsel[p];
        end
      end
      if (oreg[p] && (wide ? out_en[1] : out_en[p])) begin
        next_dout[p] = rd1[p];
      end
      if (clr[p]) begin
        next_req[p]  = '0;
        next_vld[p]  = 1'h0;
        next_rd1[p]  = 72'h0;
        next_dout[p] = 72'h0;
      end
    end
  end

  // ****************************************************
  // wishbone registers and fifo pointers
  // ****************************************************
  always_comb begin
    wb_go    = wb_cyc_i & wb_stb_i & ~ack;
    next_ack = wb_go;
    cur_word = 32'h0;
    cur_word[ldr_pkg::CFG_MODE_LSB +: 2] = cfg.mode;
    cur_word[ldr_pkg::CFG_WIDA_LSB +: 3] = cfg.wid_a;
    cur_word[ldr_pkg::CFG_WIDB_LSB +: 3] = cfg.wid_b;
    cur_word[ldr_pkg::CFG_NOPAR]         = cfg.no_par;
    cur_word[ldr_pkg::CFG_OREGA]         = cfg.oreg_a;
    cur_word[ldr_pkg::CFG_OREGB]         = cfg.oreg_b;
    cur_word[ldr_pkg::CFG_CKM_LSB +: 2]  = cfg.ckm;
    for (int b = 0; b < 4; b++) begin
      merged[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : cur_word[b*8 +: 8];
    end
    next_cfg  = cfg;
    next_rej  = rej;
    next_rdat = rdat;
    next_wptr = (fifo && wr_go[0]) ? wptr + 17'h1 : wptr;
    next_rptr = (fifo && read_strobe[1]) ? rptr + 17'h1 : rptr;
    if (wb_go && wb_we_i && wb_adr_i == ldr_pkg::STAT_OFS && wb_sel_i[0] && wb_dat_i[ldr_pkg::STAT_REJ]) begin
      next_rej = 1'h0;
    end
    if (wb_go && wb_we_i && wb_adr_i == ldr_pkg::CFG_OFS) begin
      // refused shapes keep the old setup
      if (cfg_ok(merged)) begin
        next_cfg.mode   = ldr_pkg::ldr_mode_t'(merged[ldr_pkg::CFG_MODE_LSB +: 2]);
        next_cfg.wid_a  = merged[ldr_pkg::CFG_WIDA_LSB +: 3];
        next_cfg.wid_b  = merged[ldr_pkg::CFG_WIDB_LSB +: 3];
        next_cfg.no_par = merged[ldr_pkg::CFG_NOPAR];
        next_cfg.oreg_a = merged[ldr_pkg::CFG_OREGA];
        next_cfg.oreg_b = merged[ldr_pkg::CFG_OREGB];
        next_cfg.ckm    = ldr_pkg::ldr_ckm_t'(merged[ldr_pkg::CFG_CKM_LSB +: 2]);
        next_wptr       = 17'h0_0000;
        next_rptr       = 17'h0_0000;
      end else begin
        next_rej = 1'h1;
      end
    end
    if (wb_go && !wb_we_i) begin
      next_rdat = 32'h0;
      if (wb_adr_i == ldr_pkg::CFG_OFS) begin
        next_rdat = cur_word;
      end else if (wb_adr_i == ldr_pkg::STAT_OFS) begin
        next_rdat[ldr_pkg::STAT_REJ]       = rej;
        next_rdat[ldr_pkg::STAT_EMPTY]     = empty;
        next_rdat[ldr_pkg::STAT_FULL]      = full;
        next_rdat[ldr_pkg::STAT_LVL +: 17] = level;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg    <= ldr_pkg::CFG_RST;
      rej    <= 1'h0;
      ack    <= 1'h0;
      rdat   <= 32'h0;
      wptr   <= 17'h0_0000;
      rptr   <= 17'h0_0000;
      hi_be  <= 8'h00;
      hi_din <= 72'h0;
      for (int p = 0; p < P; p++) begin
        req[p]  <= '0;
        vld[p]  <= 1'h0;
        rd1[p]  <= 72'h0;
        dout[p] <= 72'h0;
      end
    end else begin
      cfg    <= next_cfg;
      rej    <= next_rej;
      ack    <= next_ack;
      rdat   <= next_rdat;
      wptr   <= next_wptr;
      rptr   <= next_rptr;
      hi_be  <= next_hi_be;
      hi_din <= next_hi_din;
      for (int p = 0; p < P; p++) begin
        req[p]  <= next_req[p];
        vld[p]  <= next_vld[p];
        rd1[p]  <= next_rd1[p];
        dout[p] <= next_dout[p];
      end
    end
  end

  assign wb_dat_o = rdat;
  assign wb_ack_o = ack;
  assign dout_a_o = dout[0];
  assign dout_b_o = dout[1];

  // ****************************************************
  // checks
  // ****************************************************
  logic [11:0]  row_hold;
  logic [143:0] mem_chk;
  always_ff @(posedge clk_i) begin
    row_hold <= row_w[0];
  end
  assign mem_chk = mem[row_hold];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_rd_a;
    read_strobe[0] && !clr[0] && !wide;
  endsequence
  sequence s_cfg_wr;
    wb_go && wb_we_i && wb_adr_i == ldr_pkg::CFG_OFS;
  endsequence

  a_input_capture: assert property (in_en[0] && !clr[0] |=> req[0] == $past(req_in[0]))
    else $error("port a inputs not captured");
  a_bypass_lat: assert property (s_rd_a ##0 !cfg.oreg_a |=> dout[0] == $past(rsel[0]))
    else $error("bypassed read data late or wrong");
  a_oreg_lat: assert property (s_rd_a ##0 cfg.oreg_a ##1 (out_en[0] && !clr[0] && cfg.oreg_a)
                               |=> dout[0] == $past(rsel[0], 2))
    else $error("registered read data not two clocks after");
  a_clear_port: assert property (clr[0] |=> dout[0] == 72'h0 && !vld[0] && !wr_go[0])
    else $error("port clear did not reset port registers");
  a_b_readonly: assert property (!tdp |-> !wr_go[1])
    else $error("port b wrote outside true dual-port");
  a_mask_keeps: assert property (wr_go[0] && !wr_go[1]
                                 |=> (mem_chk & ~$past(bm[0])) === ($past(rrow[0]) & ~$past(bm[0])))
    else $error("masked lane changed");
  a_narrow_mask: assert property (wr_go[0] && cfg.wid_a == ldr_pkg::WID_9 |-> $onehot(lm[0]))
    else $error("narrow write lane mask wrong");
  a_wide_tdp: assert property (s_cfg_wr ##0 (wb_sel_i == 4'hf && wb_dat_i[1:0] == 2'(ldr_pkg::MODE_TDP)
                               && wb_dat_i[ldr_pkg::CFG_WIDA_LSB +: 3] == ldr_pkg::WID_144)
                               |=> cfg == $past(cfg) && rej)
    else $error("wide shape taken in true dual-port");
  a_cfg_refuse: assert property (s_cfg_wr ##0 !cfg_ok(merged) |=> cfg == $past(cfg) && rej)
    else $error("illegal pairing taken");
endmodule
`default_nettype wire

// ---- ldr_user.sv ----
// user-logic model that drives both ports of the ram block
`timescale 1ns/1ns
`default_nettype none
module ldr_user (
  input  wire logic        clk_i,
  output logic             ce_a_o,
  output logic             clr_a_o,
  output logic             we_a_o,
  output logic      [15:0] addr_a_o,
  output logic      [7:0]  be_a_o,
  output logic      [71:0] din_a_o,
  output logic             ce_b_o,
  output logic             clr_b_o,
  output logic             we_b_o,
  output logic      [15:0] addr_b_o,
  output logic      [7:0]  be_b_o,
  output logic      [71:0] din_b_o
);
  // ****************************************
  // idle levels
  // ****************************************
  initial begin
    {ce_a_o, clr_a_o, we_a_o, addr_a_o, be_a_o, din_a_o} = '0;
    {ce_b_o, clr_b_o, we_b_o, addr_b_o, be_b_o, din_b_o} = '0;
  end

  // ****************************************
  // port requests
  // ****************************************
  // enable, select per port
  task automatic req(input logic pb, input logic we, input logic [15:0] addr, input logic [7:0] be,
                     input logic [71:0] din, input int hold);
    @(posedge clk_i);
    if (pb) begin
      {ce_b_o, we_b_o, addr_b_o, be_b_o, din_b_o} <= {1'h1, we, addr, be, din};
    end else begin
      {ce_a_o, we_a_o, addr_a_o, be_a_o, din_a_o} <= {1'h1, we, addr, be, din};
    end
    repeat (hold) @(posedge clk_i);
    // released lines show the inverse of the last value
    if (pb) begin
      {ce_b_o, we_b_o, addr_b_o, be_b_o, din_b_o} <= {1'h0, ~we, ~addr, ~be, ~din};
    end else begin
      {ce_a_o, we_a_o, addr_a_o, be_a_o, din_a_o} <= {1'h0, ~we, ~addr, ~be, ~din};
    end
  endtask

  task automatic clear(input logic pb);
    @(posedge clk_i);
    clr_b_o <= pb;
    clr_a_o <= ~pb;
    @(posedge clk_i);
    clr_a_o <= 1'h0;
    clr_b_o <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench of the large dual-port ram block
`timescale 1ns/1ns
`default_nettype none
`define CHK(name, exp, got) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", name, exp, got); end end
module tb;
  typedef struct packed {
    logic [7:0]  be;
    logic [71:0] want;
  } ldr_row_t;
  logic        clk_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        ce_a, clr_a, we_a, ce_b, clr_b, we_b;
  logic [15:0] addr_a, addr_b;
  logic [7:0]  be_a, be_b;
  logic [71:0] din_a, din_b, dout_a_o, dout_b_o;
  int          num_errors, n_compared;
  ldr_row_t    rows [5] = '{'{8'h00, 72'h00_0000_0000_0000_0000}, '{8'hFF, 72'hFF_FFFF_FFFF_FFFF_FFFF},
                            '{8'h01, 72'h00_0000_0000_0000_01FF}, '{8'h80, 72'hFF_8000_0000_0000_0000},
                            '{8'h03, 72'h00_0000_0000_0003_FFFF}};

  ldr_ram i_ldr_ram (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ce_a_i(ce_a), .clr_a_i(clr_a), .we_a_i(we_a), .addr_a_i(addr_a), .be_a_i(be_a),
    .din_a_i(din_a), .dout_a_o(dout_a_o), .ce_b_i(ce_b), .clr_b_i(clr_b), .we_b_i(we_b), .addr_b_i(addr_b),
    .be_b_i(be_b), .din_b_i(din_b), .dout_b_o(dout_b_o));
  ldr_user i_ldr_user (.clk_i(clk_i), .ce_a_o(ce_a), .clr_a_o(clr_a), .we_a_o(we_a), .addr_a_o(addr_a),
    .be_a_o(be_a), .din_a_o(din_a), .ce_b_o(ce_b), .clr_b_o(clr_b), .we_b_o(we_b), .addr_b_o(addr_b),
    .be_b_o(be_b), .din_b_o(din_b));

  initial begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end

  // ****************************************
  // closing report
  // ****************************************
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // wishbone classic cycle
  // ****************************************
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, adr, 4'hF, dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_dat_i} <= {2'h0, ~dat};
    if (wb_ack_o !== 1'h1) begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic reg_chk(input logic [7:0] adr, input logic [31:0] msk, input logic [31:0] want);
    wb(1'h0, adr, 32'h0000_0000, rd);
    `CHK("register", want, rd & msk)
  endtask

  task automatic rd_chk(input logic pb, input logic [15:0] addr, input logic [71:0] want);
    i_ldr_user.req(pb, 1'h0, addr, 8'hFF, 72'h00_0000_0000_0000_0000, 1);
    @(posedge clk_i);
    #1;
    `CHK("read data", want, pb ? dout_b_o : dout_a_o)
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    num_errors = 0;
    n_compared = 0;
    {sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {1'h1, 11'h000, 4'hF, 32'h0};
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    #1;
    `CHK("reset outputs", 146'h0, {wb_ack_o, wb_dat_o[0], dout_a_o, dout_b_o})
    reg_chk(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      wb(1'h1, 8'h00, 32'h0000_006C | m, rd);
      reg_chk(8'h00, 32'hFFFF_FFFF, 32'h0000_006C | m);
      reg_chk(8'h04, 32'h0000_0001, 32'h0000_0000);
    end
    $display("test modes done");
    wb(1'h1, 8'h00, 32'h0000_006C, rd);
    for (int i = 0; i < 5; i++) begin
      i_ldr_user.req(1'h0, 1'h1, 16'(i), 8'hFF, 72'h00_0000_0000_0000_0000, 1);
      i_ldr_user.req(1'h0, 1'h1, 16'(i), rows[i].be, 72'hFF_FFFF_FFFF_FFFF_FFFF, 1);
      rd_chk(1'h1, 16'(i), rows[i].want);
    end
    $display("test lane mask rows done");
    rd_chk(1'h0, 16'h0004, rows[4].want);
    i_ldr_user.req(1'h0, 1'h0, 16'h0000, 8'hFF, 72'hFF_FFFF_FFFF_FFFF_FFFF, 1);
    rd_chk(1'h1, 16'h0000, 72'h00_0000_0000_0000_0000);
    $display("test read select done");
    wb(1'h1, 8'h00, 32'h0000_066C, rd);
    fork
      i_ldr_user.req(1'h1, 1'h0, 16'h0001, 8'hFF, 72'h00_0000_0000_0000_0000, 3);
      begin
        repeat (3) @(posedge clk_i);
        #1;
        `CHK("early output", 72'h00_0000_0000_0000_0000, dout_b_o)
        @(posedge clk_i);
        #1;
        `CHK("registered output", rows[1].want, dout_b_o)
      end
    join
    $display("test output register done");
    i_ldr_user.clear(1'h1);
    #1;
    `CHK("cleared output", 72'h00_0000_0000_0000_0000, dout_b_o)
    i_ldr_user.req(1'h1, 1'h0, 16'h0001, 8'hFF, 72'h00_0000_0000_0000_0000, 3);
    #1;
    `CHK("kept contents", rows[1].want, dout_b_o)
    i_ldr_user.req(1'h0, 1'h0, 16'h0001, 8'hFF, 72'h00_0000_0000_0000_0000, 3);
    #1;
    `CHK("registered output a", rows[1].want, dout_a_o)
    i_ldr_user.clear(1'h0);
    #1;
    `CHK("cleared output a", 72'h00_0000_0000_0000_0000, dout_a_o)
    $display("test clear done");
    wb(1'h1, 8'h00, 32'h0000_0010, rd);
    reg_chk(8'h04, 32'h0000_0001, 32'h0000_0001);
    reg_chk(8'h00, 32'hFFFF_FFFF, 32'h0000_066C);
    wb(1'h1, 8'h04, 32'h0000_0001, rd);
    reg_chk(8'h04, 32'h0000_0001, 32'h0000_0000);
    reg_chk(8'h08, 32'hFFFF_FFFF, 32'h0000_0000);
    wb(1'h1, 8'h0C, 32'hFFFF_FFFF, rd);
    reg_chk(8'h00, 32'hFFFF_FFFF, 32'h0000_066C);
    $display("test refusals done");
    wb(1'h1, 8'h00, 32'h0000_0000, rd);
    i_ldr_user.req(1'h0, 1'h1, 16'h0000, 8'h00, 72'h00_0000_0000_0000_01FF, 1);
    i_ldr_user.req(1'h1, 1'h0, 16'h0000, 8'hFF, 72'h00_0000_0000_0000_0000, 1);
    @(posedge clk_i);
    #1;
    `CHK("narrow write", 9'h1FF, dout_b_o[8:0])
    $display("test narrow shape done");
    wb(1'h1, 8'h00, 32'h0000_006F, rd);
    i_ldr_user.req(1'h0, 1'h1, 16'h0000, 8'hFF, 72'h12_3456_789A_BCDE_F012, 1);
    i_ldr_user.req(1'h0, 1'h1, 16'h0000, 8'hFF, 72'h0F_EDCB_A987_6543_210F, 1);
    reg_chk(8'h04, 32'h01FF_FFFF, 32'h0000_0200);
    rd_chk(1'h1, 16'h0000, 72'h12_3456_789A_BCDE_F012);
    rd_chk(1'h1, 16'h0000, 72'h0F_EDCB_A987_6543_210F);
    reg_chk(8'h04, 32'h01FF_FFFF, 32'h0000_0002);
    $display("test fifo done");
    wb(1'h1, 8'h00, 32'h0000_016C, rd);
    i_ldr_user.req(1'h0, 1'h1, 16'h0006, 8'hFF, 72'hFF_FFFF_FFFF_FFFF_FFFF, 1);
    i_ldr_user.req(1'h0, 1'h1, 16'h0006, 8'h01, 72'h00_0000_0000_0000_0000, 1);
    rd_chk(1'h0, 16'h0006, 72'h00_FFFF_FFFF_FFFF_FF00);
    $display("test byte lanes done");
    conclude();
  end
endmodule
`undef CHK
`default_nettype wire
